// *** src/dmaerg_pkg.sv ***
// Package for the external request and grant handshake of the DMA block
package dmaerg_pkg;
   // Channel request source codes
   localparam logic [1:0] SRC_INTERNAL = 2'h0;
   localparam logic [1:0] SRC_EXTERNAL = 2'h1;
   // Least grant time in ns
   localparam int GRANT_MIN_NS = 64;
   localparam int CLK_PERIOD_NS = 8;
   // Least grant length in cycles, rounded up
   localparam int GRANT_MIN_CYC = (GRANT_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   // Default burst length in cycles
   localparam int BURST_LEN_DEF = 8;
   // Reset values
   localparam logic GRANT_N_RST = 1'b1;

   // Per-channel configuration as a carrier
   typedef struct packed {
      logic [1:0] requestSourceSelect;
      logic requestEnable;
      logic channelEnableBit;
   } dmaerg_cfg_t;

   // Burst controller states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BURST = 2'b01,
      ST_DONE = 2'b10
   } dmaerg_state_t;
endpackage

// *** src/dmaerg_arbiter.sv ***
// Fixed-priority picker with a one-burst demotion of the external channel
`timescale 1ns/1ps
`default_nettype none
module dmaerg_arbiter #(
   parameter int NCH = 4
) (
   input wire logic [NCH-1:0] pending,
   input wire logic [NCH-1:0] demote,
   output logic [NCH-1:0] winner
);
   // Demoted channels only win when nothing else pends
   logic [NCH-1:0] firstSet;
   logic [NCH-1:0] secondSet;
   logic [NCH-1:0] primary;
   logic anyPrimary;

   // Elaboration check
   if (NCH < 1) begin : g_chk
      $error("dmaerg_arbiter: bad channel count");
   end

   assign primary = pending & ~demote;
   assign anyPrimary = |primary;
   genvar i;
   generate
      for (i = 0; i < NCH; i++) begin : g_pick
         if (i == 0) begin : g_first
            assign firstSet[i] = primary[i];
            assign secondSet[i] = pending[i];
         end else begin : g_rest
            assign firstSet[i] = primary[i] & ~|primary[i-1:0];
            assign secondSet[i] = pending[i] & ~|pending[i-1:0];
         end
      end
   endgenerate
   assign winner = anyPrimary ? firstSet : secondSet;
endmodule // dmaerg_arbiter
`default_nettype wire

// *** src/dmaerg_top.sv ***
// External DMA request and grant handshake with channel arbitration
// Summary of operation
// R1: Burst starts when channel wins priority
// R2: Peripheral holds request until serviced
// R3: Each request yields at least one burst
// R4: Grant output is active low
// R5: Grant needs external source, enables, request
// R6: Request ignored during granted burst
// R7: External channel demoted when others pend
// R8: Grant held at least eight cycles
// R9: Peripheral drops request within nine cycles
// R10: After first read, drop within eight
// R11: After first write, drop within three
// R12: Grant released, sampling resumes next cycle
//
// Cycle walk of one external transfer
// Edge 0: request and qualifiers sampled while idle
// Edge 0: arbiter picks the lowest pending index
// Edge 1: grant low, burst flag high, channel one-hot
// Edge 1 to 1+LEN: burst runs, request not sampled
// Edge 1+LEN: grant high, burst flag low, channel clear
// Edge 1+LEN: done pulse raised for one cycle
// Edge 1+LEN: dead cycle, request still ignored
// Edge 2+LEN: idle again, request sampled anew
//
// Grant length
// Burst length never below the least grant time
// Short bursts are stretched to that minimum
// Counter runs from zero to LEN-1 in the burst
// Counter parked at zero outside bursts
//
// Request qualification
// External channel needs the external source code
// It also needs both enable bits set
// Other channels need only their two enable bits
// Request bit of the external index is unused
//
// Priority
// Lowest channel index wins in the common case
// External channel demoted after its own burst
// Demotion only bites while another channel pends
// Demotion cleared once any other channel is served
// So a lone external requester is never starved
//
// Hazards and limits
// Peripheral must drop its request inside the burst
// A request still high at the idle sample rebursts
// Config changes mid-burst do not cut the burst
// Grant only reflects qualifiers at the start edge
// Internal bursts never touch the grant pin
// All inputs taken as synchronous to the clock
// No buffering, no datapath, sequencing only
//
// Outputs
// Every output comes straight from a flip-flop
// Grant idles high, active level is low
// Burst channel is zero whenever no burst runs
// Done pulse lasts exactly one cycle
//
// Reset
// Asynchronous, active low
// Grant high, all other outputs low during reset
// State machine returns to idle, counter to zero
// Demotion flag cleared, first request may follow
//
// State codes
// Idle waits for a winner
// Burst counts the granted cycles
// Done is the single dead cycle after a burst
// The fourth code is illegal and falls back to idle
`timescale 1ns/1ps
`default_nettype none
module dmaerg_top #(
   parameter int NCH = 4,
   parameter int EXT_CH = 0,
   parameter int BURST_LEN = dmaerg_pkg::BURST_LEN_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic extRequest,
   input wire logic [NCH-1:0] intRequest,
   input wire dmaerg_pkg::dmaerg_cfg_t [NCH-1:0] chanCfg,
   output logic extGrant_n,
   output logic burstActive,
   output logic [NCH-1:0] burstChannel,
   output logic burstDone
);
   localparam int LEN = (BURST_LEN > dmaerg_pkg::GRANT_MIN_CYC)
                        ? BURST_LEN : dmaerg_pkg::GRANT_MIN_CYC;
   localparam int CW = $clog2(LEN + 1);

   // Elaboration checks
   if (NCH < 1 || EXT_CH < 0 || EXT_CH >= NCH || BURST_LEN < 1) begin : g_chk
      $error("dmaerg_top: bad parameters");
   end

   dmaerg_pkg::dmaerg_state_t state;
   dmaerg_pkg::dmaerg_state_t next_state;
   logic [CW-1:0] count;
   logic [NCH-1:0] pending;
   logic [NCH-1:0] demote;
   logic [NCH-1:0] winner;
   logic [NCH-1:0] demoteExt;
   logic demoteFlag;
   logic extSelected;
   logic extOk;
   logic otherPending;
   logic startBurst;
   logic lastCycle;
   logic grantStart;

   ////////////////////////////////////////////////////////////////////////
   // Request qualification
   assign extSelected = chanCfg[EXT_CH].requestSourceSelect
                        == dmaerg_pkg::SRC_EXTERNAL;
   assign extOk = extSelected & chanCfg[EXT_CH].requestEnable
                  & chanCfg[EXT_CH].channelEnableBit; // R5

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_pend
         if (c == EXT_CH) begin : g_ext
            // Sampled only while idle
            assign pending[c] = extOk & extRequest
                                & (state == dmaerg_pkg::ST_IDLE); // R6 R12
         end else begin : g_int
            assign pending[c] = chanCfg[c].requestEnable
                                & chanCfg[c].channelEnableBit
                                & intRequest[c]
                                & (state == dmaerg_pkg::ST_IDLE);
         end
         assign demoteExt[c] = (c == EXT_CH) ? demoteFlag : 1'b0;
      end
   endgenerate

   assign otherPending = |(pending & ~demoteExt & ~(NCH'(1) << EXT_CH));
   assign demote = otherPending ? demoteExt : '0; // R7

   dmaerg_arbiter #(
      .NCH(NCH)
   ) u_arb (
      .pending(pending),
      .demote(demote),
      .winner(winner)
   );

   ////////////////////////////////////////////////////////////////////////
   // Burst sequencing
   assign startBurst = |winner; // R1 R3
   assign grantStart = winner[EXT_CH];
   assign lastCycle = count == CW'(LEN - 1);

   always_comb begin
      next_state = state;
      unique case (state)
         dmaerg_pkg::ST_IDLE: begin
            if (startBurst) begin
               next_state = dmaerg_pkg::ST_BURST;
            end
         end
         dmaerg_pkg::ST_BURST: begin
            if (lastCycle) begin
               next_state = dmaerg_pkg::ST_DONE;
            end
         end
         dmaerg_pkg::ST_DONE: begin
            next_state = dmaerg_pkg::ST_IDLE; // R12
         end
         default: begin
            next_state = dmaerg_pkg::ST_IDLE;
         end
      endcase
   end

   // State and burst counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dmaerg_pkg::ST_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= (state == dmaerg_pkg::ST_BURST && !lastCycle)
                  ? count + CW'(1) : '0; // R8
      end
   end

   // Demotion after an external burst, kept until another channel is served
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         demoteFlag <= 1'b0;
      end else if (startBurst) begin
         demoteFlag <= grantStart; // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extGrant_n <= dmaerg_pkg::GRANT_N_RST;
         burstActive <= 1'b0;
         burstChannel <= '0;
         burstDone <= 1'b0;
      end else begin
         if (state == dmaerg_pkg::ST_IDLE && startBurst) begin
            extGrant_n <= ~grantStart; // R4 R5
            burstActive <= 1'b1;
            burstChannel <= winner;
         end else if (state == dmaerg_pkg::ST_BURST && lastCycle) begin
            extGrant_n <= 1'b1; // R12
            burstActive <= 1'b0;
            burstChannel <= '0;
         end
         burstDone <= state == dmaerg_pkg::ST_BURST && lastCycle;
      end
   end
endmodule // dmaerg_top
`default_nettype wire

// *** tb/dmaerg_asserts.sv ***
// Property checker for the external request and grant handshake
`timescale 1ns/1ps
`default_nettype none
module dmaerg_asserts #(
   parameter int NCH = 4,
   parameter int EXT_CH = 0,
   parameter int BURST_LEN = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic extRequest,
   input wire logic [NCH-1:0] intRequest,
   input wire dmaerg_pkg::dmaerg_cfg_t [NCH-1:0] chanCfg,
   input wire logic extGrant_n,
   input wire logic burstActive,
   input wire logic [NCH-1:0] burstChannel,
   input wire logic burstDone
);
   logic [NCH-1:0] en;
   logic extOk;
   logic others;
   // Enabled channels, external qualification, rival requests
   always_comb begin
      foreach (en[i]) begin
         en[i] = chanCfg[i].requestEnable & chanCfg[i].channelEnableBit;
      end
   end
   assign extOk = en[EXT_CH] && chanCfg[EXT_CH].requestSourceSelect
                  == dmaerg_pkg::SRC_EXTERNAL;
   assign others = |(intRequest & en & ~(NCH'(1) << EXT_CH));
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_GRANT_COND: assert property (
      $fell(extGrant_n) |-> $past(extRequest && extOk))
      else $error("grant without qualified request");
   AST_GRANT_LEN: assert property (
      $fell(extGrant_n) |-> !extGrant_n[*8] ##1 extGrant_n)
      else $error("grant length wrong");
   AST_GRANT_CH: assert property (
      $fell(extGrant_n) |-> burstActive && burstChannel[EXT_CH])
      else $error("grant outside external burst");
   AST_DONE: assert property (
      $rose(extGrant_n) |-> burstDone && !burstActive)
      else $error("grant release not at burst end");
   AST_REFUSE: assert property (
      burstDone |=> extGrant_n)
      else $error("request taken in done cycle");
   AST_SERVE: assert property (
      !burstActive && !burstDone && extRequest && extOk && !others
      |=> !extGrant_n)
      else $error("qualified request not served");
   AST_DEMOTE: assert property (
      $rose(extGrant_n) ##2 others |=> !burstChannel[EXT_CH])
      else $error("external channel not demoted");
   AST_IDLE: assert property (
      !burstActive |-> burstChannel == '0 && extGrant_n)
      else $error("grant or channel while idle");
endmodule // dmaerg_asserts
bind dmaerg_top dmaerg_asserts #(
   .NCH(NCH), .EXT_CH(EXT_CH), .BURST_LEN(BURST_LEN)
) chk (
   .clk(clk), .rst_n(rst_n), .extRequest(extRequest),
   .intRequest(intRequest), .chanCfg(chanCfg), .extGrant_n(extGrant_n),
   .burstActive(burstActive), .burstChannel(burstChannel),
   .burstDone(burstDone));
`default_nettype wire

// *** tb/dmaerg_periph.sv ***
// Peripheral model raising the external request
`timescale 1ns/1ps
`default_nettype none
module dmaerg_periph (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic want,
   input wire logic [3:0] holdCyc,
   input wire logic extGrant_n,
   output logic extRequest
);
   logic [3:0] cnt;
   logic served;
   // Count granted cycles, drop the request after the hold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         served <= 1'b0;
      end else begin
         cnt <= extGrant_n ? 4'h0 : cnt + 4'h1;
         if (!want) served <= 1'b0;
         else if (!extGrant_n && cnt >= holdCyc) served <= 1'b1;
      end
   end
   assign extRequest = want & ~served;
endmodule // dmaerg_periph
`default_nettype wire

// *** tb/dmaerg_bench.sv ***
// Random and corner bench for the external request and grant handshake
`timescale 1ns/1ps
`default_nettype none
module dmaerg_bench;
   logic clk = 1'b0, rst_n = 1'b0, want = 1'b0, extRequest, extGrant_n;
   logic burstActive, burstDone, got;
   logic [3:0] holdCyc = 4'h0, intRequest = 4'h0, burstChannel;
   dmaerg_pkg::dmaerg_cfg_t [3:0] chanCfg = '0;
   int n_errors = 0, check_count = 0, cyc = 0;
   dmaerg_top uut (.clk(clk), .rst_n(rst_n), .extRequest(extRequest),
      .intRequest(intRequest), .chanCfg(chanCfg), .extGrant_n(extGrant_n),
      .burstActive(burstActive), .burstChannel(burstChannel),
      .burstDone(burstDone));
   dmaerg_periph peer (.clk(clk), .rst_n(rst_n), .want(want),
      .holdCyc(holdCyc), .extGrant_n(extGrant_n), .extRequest(extRequest));
   // Clock and cycle ceiling
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic expOk(dmaerg_pkg::dmaerg_cfg_t c);
      return c.requestSourceSelect === dmaerg_pkg::SRC_EXTERNAL
             && c.requestEnable === 1'b1 && c.channelEnableBit === 1'b1;
   endfunction
   // Random trials, then demotion corners
   initial begin
      void'($urandom(569));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int t = 0; t < 40; t++) begin
         @(posedge clk);
         chanCfg <= {12'($urandom), 4'h7 ^ (4'h1 << ($urandom % 8))};
         intRequest <= 4'($urandom) & 4'he;
         holdCyc <= 4'($urandom % 8);
         want <= 1'b1;
         got = 1'b0;
         repeat (40) begin
            @(negedge clk);
            if (extGrant_n === 1'b0) got = 1'b1;
         end
         chk(got, expOk(chanCfg[0]));
         want <= 1'b0;
         $display("test %0d done", t);
      end
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         chanCfg <= {4{4'h7}};
         intRequest <= 4'(k * 2);
         holdCyc <= 4'hf;
         want <= 1'b1;
         for (int i = 0; i < 30 && extGrant_n !== 1'b0; i++) @(negedge clk);
         for (int i = 0; i < 30 && extGrant_n !== 1'b1; i++) @(negedge clk);
         for (int i = 0; i < 30 && burstActive !== 1'b1; i++) @(negedge clk);
         chk(burstChannel, k ? 4'h2 : 4'h1);
         want <= 1'b0;
         intRequest <= 4'h0;
         repeat (30) @(posedge clk);
         $display("corner %0d done", k);
      end
      stop_test();
   end
endmodule // dmaerg_bench
`default_nettype wire
